// >>> rtl/acc_top.sv
// Purpose: Register file and digital control around one analog comparator.
// Assumes: AXI4-Lite master issues at most one write and one read at a time.
// Notes:   All outputs are registered; writes answer two cycles after both halves.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Comparator core
    input  wire logic        comparator_result,
    output logic             neg_use_pin,
    output logic             pos_use_pin,
    output logic             pos_use_ladder,
    // Resistor ladder
    output logic             ladder_power,
    output logic             ladder_range,
    output logic [5:0]       ladder_tap,
    output logic [5:0]       ladder_units,
    // Device pin and events
    output logic             result_output_pin,
    output logic             irq,
    output logic             converter_trigger
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [31:0] wmask_q, wmask_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        raw_q, raw_d, irq_en_q, irq_en_d;
    logic [31:0] ref_ctl_q, ref_ctl_d, cmp_ctl_q, cmp_ctl_d;
    logic        neg_pin_q, neg_pin_d, pos_pin_q, pos_pin_d, pos_lad_q, pos_lad_d;
    logic        power_q, power_d, range_q, range_d;
    logic [5:0]  tap_q, tap_d, units_q, units_d;
    logic        pin_q, pin_d, irq_q, irq_d, trig_q, trig_d;

    logic        cmp_level;
    logic        irq_event;
    logic        trig_event;
    logic        masked;
    logic        do_write;
    logic        clear_irq;
    acc_src_t    src;

    // ****************************************************************
    // Comparator result path
    // ****************************************************************
    acc_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (comparator_result),
        .sync_out (cmp_level)
    );

    // Two separate detectors so the interrupt and trigger senses differ.
    acc_sense u_irq_sense (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .sense       (acc_sense_t'(cmp_ctl_q[ACC_CTL_ISENSE_LSB +: 2])),
        .level_value (cmp_ctl_q[ACC_CTL_ILEVEL_BIT]),
        .level       (cmp_level),
        .event_out   (irq_event)
    );

    acc_sense u_trig_sense (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .sense       (acc_sense_t'(cmp_ctl_q[ACC_CTL_TSENSE_LSB +: 2])),
        .level_value (cmp_ctl_q[ACC_CTL_TLEVEL_BIT]),
        .level       (cmp_level),
        .event_out   (trig_event)
    );

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m, input logic [31:0] wr);
        return (old & ~(m & wr)) | (nw & m & wr);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        awready_d = awready_q;
        wready_d  = wready_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wmask_d   = wmask_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        irq_en_d  = irq_en_q;
        ref_ctl_d = ref_ctl_q;
        cmp_ctl_d = cmp_ctl_q;
        clear_irq = 1'b0;
        masked    = raw_q & irq_en_q;

        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awready_d = 1'b0;
            waddr_d   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wready_d = 1'b0;
            wdata_d  = s_axi_wdata;
            wmask_d  = strb_mask(s_axi_wstrb);
        end

        do_write = aw_have_q && w_have_q && !bvalid_q;
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = ACC_RESP_OKAY;
            unique case (waddr_q[7:2])
                ACC_OFF_MASKED_IRQ_STATUS[7:2]: begin
                    clear_irq = wmask_q[ACC_IRQ_BIT] & wdata_q[ACC_IRQ_BIT];
                end
                ACC_OFF_IRQ_ENABLE[7:2]: begin
                    irq_en_d = merge({31'h0, irq_en_q}, wdata_q, wmask_q, ACC_MASK_IRQ_ENABLE) != 32'h0;
                end
                ACC_OFF_REFERENCE_CONTROL[7:2]: begin
                    ref_ctl_d = merge(ref_ctl_q, wdata_q, wmask_q, ACC_MASK_REF_CTL);
                end
                ACC_OFF_COMPARATOR_CONTROL[7:2]: begin
                    cmp_ctl_d = merge(cmp_ctl_q, wdata_q, wmask_q, ACC_MASK_CMP_CTL);
                end
                ACC_OFF_RAW_IRQ_STATUS[7:2], ACC_OFF_COMPARATOR_STATUS[7:2]: begin
                    bresp_d = ACC_RESP_OKAY;
                end
                default: begin
                    bresp_d = ACC_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d  = 1'b0;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end

        // Read: one request at a time, data the cycle after acceptance.
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = ACC_RESP_OKAY;
            rdata_d   = 32'h00000000;
            unique case (s_axi_araddr[7:2])
                ACC_OFF_MASKED_IRQ_STATUS[7:2]: begin
                    rdata_d[ACC_IRQ_BIT] = masked;
                end
                ACC_OFF_RAW_IRQ_STATUS[7:2]: begin
                    rdata_d[ACC_IRQ_BIT] = raw_q;
                end
                ACC_OFF_IRQ_ENABLE[7:2]: begin
                    rdata_d[ACC_IRQ_BIT] = irq_en_q;
                end
                ACC_OFF_REFERENCE_CONTROL[7:2]: begin
                    rdata_d = ref_ctl_q;
                end
                ACC_OFF_COMPARATOR_STATUS[7:2]: begin
                    rdata_d[ACC_STAT_LEVEL_BIT] = cmp_level;
                end
                ACC_OFF_COMPARATOR_CONTROL[7:2]: begin
                    rdata_d = cmp_ctl_q;
                end
                default: begin
                    rresp_d = ACC_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end

        // Raw status is sticky; a new event wins over a clear in the same cycle.
        raw_d = irq_event | (raw_q & ~clear_irq);

        // Comparator routing and ladder decode.
        src       = acc_src_t'(cmp_ctl_q[ACC_CTL_SRC_LSB +: 2]);
        neg_pin_d = 1'b1;
        pos_pin_d = (src == ACC_SRC_PIN) || (src == ACC_SRC_PIN_ALT);
        pos_lad_d = (src == ACC_SRC_LADDER);
        power_d   = ref_ctl_q[ACC_REF_POWER_BIT];
        range_d   = ref_ctl_q[ACC_REF_RANGE_BIT];
        if (!power_d) begin
            tap_d   = 6'h00;
            units_d = range_d ? ACC_LADDER_UNITS_SHORT : ACC_LADDER_UNITS_LONG;
        end else if (!range_d) begin
            tap_d   = {2'b00, ref_ctl_q[ACC_REF_TAP_LSB +: ACC_REF_TAP_W]} + ACC_LADDER_TAP_OFFSET;
            units_d = ACC_LADDER_UNITS_LONG;
        end else begin
            tap_d   = {2'b00, ref_ctl_q[ACC_REF_TAP_LSB +: ACC_REF_TAP_W]};
            units_d = ACC_LADDER_UNITS_SHORT;
        end

        pin_d  = cmp_level ^ cmp_ctl_q[ACC_CTL_INVERT_BIT];
        irq_d  = raw_d & irq_en_d;
        trig_d = trig_event & cmp_ctl_q[ACC_CTL_CONV_EN_BIT];

        if (!aresetn) begin
            awready_d = 1'b1;
            wready_d  = 1'b1;
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            waddr_d   = 8'h00;
            wdata_d   = ACC_REG_RESET;
            wmask_d   = ACC_REG_RESET;
            bvalid_d  = 1'b0;
            bresp_d   = ACC_RESP_OKAY;
            arready_d = 1'b1;
            rvalid_d  = 1'b0;
            rdata_d   = ACC_REG_RESET;
            rresp_d   = ACC_RESP_OKAY;
            raw_d     = 1'b0;
            irq_en_d  = 1'b0;
            ref_ctl_d = ACC_REG_RESET;
            cmp_ctl_d = ACC_REG_RESET;
            neg_pin_d = 1'b1;
            pos_pin_d = 1'b1;
            pos_lad_d = 1'b0;
            power_d   = 1'b0;
            range_d   = 1'b0;
            tap_d     = 6'h00;
            units_d   = ACC_LADDER_UNITS_LONG;
            pin_d     = 1'b0;
            irq_d     = 1'b0;
            trig_d    = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        awready_q <= awready_d;
        wready_q  <= wready_d;
        aw_have_q <= aw_have_d;
        w_have_q  <= w_have_d;
        waddr_q   <= waddr_d;
        wdata_q   <= wdata_d;
        wmask_q   <= wmask_d;
        bvalid_q  <= bvalid_d;
        bresp_q   <= bresp_d;
        arready_q <= arready_d;
        rvalid_q  <= rvalid_d;
        rdata_q   <= rdata_d;
        rresp_q   <= rresp_d;
        raw_q     <= raw_d;
        irq_en_q  <= irq_en_d;
        ref_ctl_q <= ref_ctl_d;
        cmp_ctl_q <= cmp_ctl_d;
        neg_pin_q <= neg_pin_d;
        pos_pin_q <= pos_pin_d;
        pos_lad_q <= pos_lad_d;
        power_q   <= power_d;
        range_q   <= range_d;
        tap_q     <= tap_d;
        units_q   <= units_d;
        pin_q     <= pin_d;
        irq_q     <= irq_d;
        trig_q    <= trig_d;
    end

    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rdata       = rdata_q;
    assign s_axi_rresp       = rresp_q;
    assign neg_use_pin       = neg_pin_q;
    assign pos_use_pin       = pos_pin_q;
    assign pos_use_ladder    = pos_lad_q;
    assign ladder_power      = power_q;
    assign ladder_range      = range_q;
    assign ladder_tap        = tap_q;
    assign ladder_units      = units_q;
    assign result_output_pin = pin_q;
    assign irq               = irq_q;
    assign converter_trigger = trig_q;
endmodule

// >>> rtl/acc_pkg.sv
// Purpose: Constants and types shared by the analog comparator control block.
// Assumes: One comparator, one resistor ladder, registers on AXI4-Lite.
// Notes:   Contract list below names each behaviour the block keeps.
// Contract
// - Interrupt and trigger from independent event paths.
// - Comparator result can drive a device pin.
// - Negative input always from its dedicated pin.
// - Source codes 00/01 pin, 10 ladder, 11 reserved.
// - Ladder unpowered gives ground reference always.
// - Powered, range clear: tap plus eight of 32.
// - Powered, range set: tap of 24 units.
// - Writing one to masked status clears interrupt.
// - Interrupt forwarded only when enabled; raw always.
// - Converter event forwarded only when enable set.
// - Status bit one shows present output level.
package acc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ACC_OFF_MASKED_IRQ_STATUS = 8'h00;
    localparam logic [7:0] ACC_OFF_RAW_IRQ_STATUS    = 8'h04;
    localparam logic [7:0] ACC_OFF_IRQ_ENABLE        = 8'h08;
    localparam logic [7:0] ACC_OFF_REFERENCE_CONTROL = 8'h10;
    localparam logic [7:0] ACC_OFF_COMPARATOR_STATUS = 8'h20;
    localparam logic [7:0] ACC_OFF_COMPARATOR_CONTROL = 8'h24;
    localparam logic [31:0] ACC_REG_RESET             = 32'h00000000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ACC_IRQ_BIT          = 0;
    localparam int ACC_REF_TAP_LSB      = 0;
    localparam int ACC_REF_TAP_W        = 4;
    localparam int ACC_REF_RANGE_BIT    = 8;
    localparam int ACC_REF_POWER_BIT    = 9;
    localparam int ACC_STAT_LEVEL_BIT   = 1;
    localparam int ACC_CTL_INVERT_BIT   = 1;
    localparam int ACC_CTL_ISENSE_LSB   = 2;
    localparam int ACC_CTL_ILEVEL_BIT   = 4;
    localparam int ACC_CTL_TSENSE_LSB   = 5;
    localparam int ACC_CTL_TLEVEL_BIT   = 7;
    localparam int ACC_CTL_SRC_LSB      = 9;
    localparam int ACC_CTL_CONV_EN_BIT  = 11;

    // Writable bits of each register.
    localparam logic [31:0] ACC_MASK_IRQ_ENABLE = 32'h00000001;
    localparam logic [31:0] ACC_MASK_REF_CTL    = 32'h0000030f;
    localparam logic [31:0] ACC_MASK_CMP_CTL    = 32'h00000efe;

    // ****************************************************************
    // Ladder figures
    // ****************************************************************
    localparam logic [5:0] ACC_LADDER_UNITS_LONG  = 6'h20;
    localparam logic [5:0] ACC_LADDER_UNITS_SHORT = 6'h18;
    localparam logic [5:0] ACC_LADDER_TAP_OFFSET  = 6'h08;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        ACC_SRC_PIN     = 2'b00,
        ACC_SRC_PIN_ALT = 2'b01,
        ACC_SRC_LADDER  = 2'b10,
        ACC_SRC_RSVD    = 2'b11
    } acc_src_t;

    typedef enum logic [1:0] {
        ACC_SENSE_LEVEL   = 2'b00,
        ACC_SENSE_FALLING = 2'b01,
        ACC_SENSE_RISING  = 2'b10,
        ACC_SENSE_BOTH    = 2'b11
    } acc_sense_t;

    localparam logic [1:0] ACC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'b10;

endpackage

// >>> rtl/acc_sync.sv
// Purpose: Two-stage synchronizer for the asynchronous comparator result.
// Assumes: Input changes at any time relative to aclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module acc_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Data
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = aresetn ? async_in : 1'b0;
        sync_d = aresetn ? meta_q : 1'b0;
    end

    always_ff @(posedge aclk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;
endmodule

// >>> rtl/acc_sense.sv
// Purpose: Event detector on the synchronized comparator level.
// Assumes: Level is already in the aclk domain.
// Notes:   Level mode fires every cycle the level matches.
`timescale 1ns/1ps
module acc_sense
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Configuration
    input  wire acc_sense_t sense,
    input  wire logic       level_value,
    // Level in, event out
    input  wire logic       level,
    output logic            event_out
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = aresetn ? level : 1'b0;
        unique case (sense)
            ACC_SENSE_LEVEL: begin
                event_out = (level == level_value);
            end
            ACC_SENSE_FALLING: begin
                event_out = prev_q & ~level;
            end
            ACC_SENSE_RISING: begin
                event_out = ~prev_q & level;
            end
            ACC_SENSE_BOTH: begin
                event_out = prev_q ^ level;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        prev_q <= prev_d;
    end
endmodule

// >>> testbench/acc_core_model.sv
// Purpose: Behavioural comparator core and resistor ladder.
// Assumes: Voltages in millivolts against a 3300 mV supply.
// Notes:   The result settles at once; the design syncs it.
`timescale 1ns/1ps
module acc_core_model (
    // Selection
    input  wire logic        pos_use_pin,
    input  wire logic        pos_use_ladder,
    input  wire logic [5:0]  ladder_tap,
    input  wire logic [5:0]  ladder_units,
    input  wire logic        pad_digital_input_enable,
    // Pin voltages
    input  wire logic [15:0] v_pos,
    input  wire logic [15:0] v_neg,
    // Result
    output logic             result
);
    int v_ref;
    int v_in;
    always_comb begin
        v_ref = 3300 * int'(ladder_tap) / int'(ladder_units);
        v_in = pos_use_pin ? int'(v_pos) : (pos_use_ladder ? v_ref : 0);
        result = pad_digital_input_enable ? 1'bx : v_in > int'(v_neg);
    end
endmodule

// >>> testbench/acc_monitor.sv
// Purpose: Concurrent checks on the comparator control ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to the top module from the testbench.
`timescale 1ns/1ps
module acc_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Comparator, ladder and interrupt
    input wire logic        neg_use_pin,
    input wire logic        pos_use_pin,
    input wire logic        pos_use_ladder,
    input wire logic        ladder_power,
    input wire logic        ladder_range,
    input wire logic [5:0]  ladder_tap,
    input wire logic [5:0]  ladder_units,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    neg_pin_a: assert property (neg_use_pin)
        else $error("negative input off its pin");
    src_one_a: assert property (!(pos_use_pin && pos_use_ladder))
        else $error("two positive sources");
    off_gnd_a: assert property (!ladder_power |-> ladder_tap == 6'h00)
        else $error("unpowered ladder tap");
    long_tap_a: assert property (ladder_power && !ladder_range |->
        ladder_units == 6'h20 && ladder_tap >= 6'h08 && ladder_tap <= 6'h17)
        else $error("long ladder tap");
    short_tap_a: assert property (ladder_power && ladder_range |->
        ladder_units == 6'h18 && ladder_tap <= 6'h0f)
        else $error("short ladder tap");
    irq_fall_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq fell without a write");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    w_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    r_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

// >>> testbench/analog_comparator_control_test.sv
// Purpose: Register-level test of the comparator control block.
// Assumes: Hand-over latencies; W1C on masked status clears raw.
// Notes:   Expected values come from the register map and ladder math.
`timescale 1ns/1ps
module analog_comparator_control_test;
    import acc_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, pad_digital_input_enable = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [15:0] v_pos = 16'h0000, v_neg = 16'h0bb8;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        comparator_result, neg_use_pin, pos_use_pin, pos_use_ladder, ladder_power;
    logic        ladder_range, result_output_pin, irq, converter_trigger;
    logic [5:0]  ladder_tap, ladder_units;
    int          n_fail = 0, n_compared = 0, n_trig = 0;
    logic [7:0]  offs [5] = '{ACC_OFF_MASKED_IRQ_STATUS, ACC_OFF_IRQ_ENABLE, ACC_OFF_REFERENCE_CONTROL,
                              ACC_OFF_COMPARATOR_STATUS, ACC_OFF_COMPARATOR_CONTROL};
    logic [31:0] ref_wr [6] = '{32'h30c, 32'h205, 32'h200, 32'h10f, 32'h100, 32'hffffffff};
    logic [31:0] ref_rb [6] = '{32'h30c, 32'h205, 32'h200, 32'h10f, 32'h100, 32'h30f};
    logic [5:0]  tap_x [6] = '{6'h0c, 6'h0d, 6'h08, 6'h00, 6'h00, 6'h0f};
    logic [5:0]  unit_x [6] = '{6'h18, 6'h20, 6'h20, 6'h18, 6'h18, 6'h18};

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (converter_trigger === 1'b1) n_trig <= n_trig + 1;

    acc_top acc_top_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .comparator_result, .neg_use_pin, .pos_use_pin,
        .pos_use_ladder, .ladder_power, .ladder_range, .ladder_tap, .ladder_units, .result_output_pin,
        .irq, .converter_trigger);
    acc_core_model acc_core_model_i (.pos_use_pin, .pos_use_ladder, .ladder_tap, .ladder_units,
        .v_pos, .v_neg, .pad_digital_input_enable, .result(comparator_result));

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
        @(posedge aclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
        @(posedge aclk);
    endtask

    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (offs[i]) rchk(offs[i], 32'h0, ACC_RESP_OKAY);
        rchk(ACC_OFF_RAW_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            wr(ACC_OFF_REFERENCE_CONTROL, ref_wr[i], ACC_RESP_OKAY);
            rchk(ACC_OFF_REFERENCE_CONTROL, ref_rb[i], ACC_RESP_OKAY);
            chk(32'({ladder_power, ladder_range, ladder_tap}), 32'({ref_rb[i][9:8], tap_x[i]}));
            chk(32'(ladder_units), 32'(unit_x[i]));
        end
        for (int i = 0; i < 4; i++) begin
            wr(ACC_OFF_COMPARATOR_CONTROL, 32'(i) << 9, ACC_RESP_OKAY);
            chk(32'(pos_use_pin), 32'(i < 2));
            chk(32'(pos_use_ladder), 32'(i == 2));
            chk(32'(neg_use_pin), 32'h1);
        end
        wr(ACC_OFF_REFERENCE_CONTROL, 32'h30c, ACC_RESP_OKAY);
        wr(ACC_OFF_COMPARATOR_CONTROL, 32'hc28, ACC_RESP_OKAY);
        wr(ACC_OFF_MASKED_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        rchk(ACC_OFF_RAW_IRQ_STATUS, 32'h0, ACC_RESP_OKAY);
        v_neg <= 16'h03e8;
        repeat (6) @(posedge aclk);
        rchk(ACC_OFF_RAW_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        rchk(ACC_OFF_MASKED_IRQ_STATUS, 32'h0, ACC_RESP_OKAY);
        rchk(ACC_OFF_COMPARATOR_STATUS, 32'h2, ACC_RESP_OKAY);
        chk(32'(irq), 32'h0);
        chk(32'(result_output_pin), 32'h1);
        wr(ACC_OFF_RAW_IRQ_STATUS, 32'h0, ACC_RESP_OKAY);
        rchk(ACC_OFF_RAW_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        wr(ACC_OFF_IRQ_ENABLE, 32'h1, ACC_RESP_OKAY);
        chk(32'(irq), 32'h1);
        rchk(ACC_OFF_MASKED_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        wr(ACC_OFF_MASKED_IRQ_STATUS, 32'h0, ACC_RESP_OKAY);
        chk(32'(irq), 32'h1);
        wr(ACC_OFF_MASKED_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        chk(32'(irq), 32'h0);
        wr(ACC_OFF_COMPARATOR_CONTROL, 32'hc2a, ACC_RESP_OKAY);
        chk(32'(result_output_pin), 32'h0);
        chk(32'(n_trig), 32'h0);
        v_neg <= 16'h0bb8;
        repeat (6) @(posedge aclk);
        chk(32'(n_trig), 32'h1);
        rchk(ACC_OFF_RAW_IRQ_STATUS, 32'h0, ACC_RESP_OKAY);
        wr(ACC_OFF_COMPARATOR_CONTROL, 32'h42a, ACC_RESP_OKAY);
        v_neg <= 16'h03e8;
        repeat (6) @(posedge aclk);
        v_neg <= 16'h0bb8;
        repeat (6) @(posedge aclk);
        chk(32'(n_trig), 32'h1);
        rchk(ACC_OFF_RAW_IRQ_STATUS, 32'h1, ACC_RESP_OKAY);
        rchk(8'h0c, 32'h0, ACC_RESP_SLVERR);
        wr(8'h30, 32'h1, ACC_RESP_SLVERR);
        finish_test();
    end

    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule

bind acc_top acc_monitor acc_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .neg_use_pin, .pos_use_pin, .pos_use_ladder,
    .ladder_power, .ladder_range, .ladder_tap, .ladder_units, .irq);
